/* File: logic/rss_reset_source_sequencer.v */
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_reset_source_sequencer #(
   parameter TIMER_CYCLES = `RSS_TIMER_MS * 1000 * `RSS_CLK_MHZ, // 64 ms at mclk
   parameter FILT_CYCLES = `RSS_FILT_CYC, // Brownout dip filter length
   parameter PIN_FILT_CYCLES = `RSS_FILT_CYC // Pin glitch filter length
) (
   input wire mclk,
   input wire rst_n,
   // Configuration word settings
   input wire powerup_timer_enable_n,
   input wire [1:0] brownout_mode_select,
   input wire brownout_level_select,
   input wire low_power_brownout_enable,
   input wire ext_reset_pin_enable,
   input wire low_voltage_programming,
   // Analog detector outputs and device state
   input wire por_active,
   input wire brownout_below,
   input wire brownout_det_ready,
   input wire low_power_brownout_below,
   input wire sleep_active,
   // Other reset sources, pulses from the core
   input wire wdt_reset,
   input wire reset_instr,
   input wire stack_overflow,
   input wire stack_underflow,
   input wire prog_exit,
   // External reset pin
   input wire external_reset_pin_in,
   output reg external_reset_pin_out,
   output reg external_reset_pin_oe_n,
   output reg pin_pullup_en,
   output reg gpio_in,
   // Analog controls
   output reg brownout_det_en,
   output reg brownout_level,
   output reg bandgap_force,
   output reg low_power_brownout_en,
   // Device-wide hold
   output reg reset_hold,
   // Register port
   input wire [`RSS_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata
);

   // Sequencer states; power-on and brownout share the top state
   localparam [2:0] ST_POR = 3'd0; // Power-on or brownout held
   localparam [2:0] ST_TIMER = 3'd1; // Powerup timer running
   localparam [2:0] ST_WAIT = 3'd2; // Waiting for pin and detector
   localparam [2:0] ST_START = 3'd3; // Ten-cycle start delay
   localparam [2:0] ST_RUN = 3'd4; // Executing
   // A supply event always lands back in ST_POR, so the timer reruns if powerup_timer_enable_n is low
   // A pin reset alone returns to ST_WAIT and skips the timer
   // Codes 5 to 7 are unused and fall back to ST_POR

   // Two-stage synchronisers, first stage read only by second
   // Bit order: pin, dip, ready, low-power, power-on, sleep
   // Reset value keeps the pin high so no false pin event follows reset
   reg [5:0] sync1_q;
   reg [5:0] sync2_q;
   wire pin_s = sync2_q[0]; // Synced pin level
   wire dip_s = sync2_q[1]; // Synced supply below threshold
   wire rdy_s = sync2_q[2]; // Synced detector ready
   wire lpb_s = sync2_q[3]; // Synced low-power trip
   wire por_s = sync2_q[4]; // Synced power-on hold
   wire slp_s = sync2_q[5]; // Synced sleep state

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [31:0] tmr_q;
   reg [31:0] tmr_d;
   reg [15:0] bfilt_q;
   reg [15:0] pfilt_q;
   reg dip_trip_q;
   reg pin_low_q;
   reg sw_en_q;
   reg fast_q;
   reg pullup_q;
   reg [7:0] cause_q;
   reg [7:0] cause_set;

   // Pin and analog inputs come from outside the clock domain
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 6'h21;
         sync2_q <= 6'h21;
      end else begin
         sync1_q <= {sleep_active, por_active, low_power_brownout_below,
                     brownout_det_ready, brownout_below, external_reset_pin_in};
         sync2_q <= sync1_q;
      end
   end

   // Pin function enable
   wire pin_en = ext_reset_pin_enable | low_voltage_programming;

   // Detector enable per mode
   reg det_on;
   reg start_wait;
   always @* begin
      det_on = 1'b0;
      start_wait = 1'b0;
      case (brownout_mode_select)
         `RSS_MODE_ON: begin
            det_on = 1'b1;
            start_wait = 1'b1;
         end
         `RSS_MODE_AWAKE: begin
            det_on = ~slp_s;
            start_wait = 1'b1;
         end
         `RSS_MODE_SW: begin
            det_on = sw_en_q;
            start_wait = 1'b0;
         end
         default: begin
            det_on = 1'b0; // Mode 00 off; software bit inert
            start_wait = 1'b0;
         end
      endcase
   end

   // Protection only counts once detector reports ready
   wire dip_armed = det_on & rdy_s;
   // Low-power detector on its own config bit, erased = 0
   wire lpb_trip = low_power_brownout_enable & lpb_s;

   // Brownout dip filter: trips only on a sustained low supply
   // Counts only while the detector is armed, so an idle or warming
   // detector can never cause a reset; the count restarts on recovery
   // Trade-off: a dip exactly at the limit still passes, erring to uptime
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bfilt_q <= 16'h0000;
         dip_trip_q <= 1'b0;
      end else if (dip_armed && dip_s) begin
         if (bfilt_q >= FILT_CYCLES[15:0]) begin
            dip_trip_q <= 1'b1;
         end else begin
            bfilt_q <= bfilt_q + 16'h0001; // Still inside the dip window
         end
      end else begin
         // Supply recovered or detector off: forget the dip
         bfilt_q <= 16'h0000;
         dip_trip_q <= 1'b0;
      end
   end

   // Pin glitch filter: short lows ignored, release is immediate
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pfilt_q <= 16'h0000;
         pin_low_q <= 1'b0;
      end else if (pin_en && !pin_s) begin
         if (pfilt_q >= PIN_FILT_CYCLES[15:0]) begin
            pin_low_q <= 1'b1;
         end else begin
            pfilt_q <= pfilt_q + 16'h0001;
         end
      end else begin
         pfilt_q <= 16'h0000;
         pin_low_q <= 1'b0;
      end
   end

   // Supply-type hold: power-on, brownout, low-power brownout
   // Any one of these sends the sequencer back to the top
   wire supply_hold = por_s | dip_trip_q | lpb_trip;
   // Ready gate for modes that wait on the detector
   // Software mode never waits, so start-up there is not delayed
   wire det_ok = !start_wait || (rdy_s && !dip_s);

   // Sequencer next state
   // The timer counter is shared by the timer and the start delay;
   // it is cleared on entry to ST_TIMER and ST_START so neither inherits a count
   // A pin reset during the start delay goes back to waiting,
   // so the ten-cycle gap always follows the last pin release
   // Limitation: the wake-up from sleep is not sequenced here;
   // the core waits on the ready bit itself in mode 10
   always @* begin
      state_d = state_q;
      tmr_d = tmr_q;
      case (state_q)
         ST_POR: begin
            tmr_d = 32'h0;
            if (!supply_hold) begin
               // Timer starts only after supply release
               state_d = powerup_timer_enable_n ? ST_WAIT : ST_TIMER;
            end
         end
         ST_TIMER: begin
            // Counts once per mclk; the full 64 ms is millions of cycles
            tmr_d = tmr_q + 32'h1;
            if (tmr_q >= TIMER_CYCLES - 1) begin
               state_d = ST_WAIT;
               tmr_d = 32'h0;
            end
         end
         ST_WAIT: begin
            tmr_d = 32'h0;
            if (!pin_low_q && det_ok) begin
               state_d = ST_START;
            end
         end
         ST_START: begin
            tmr_d = tmr_q + 32'h1;
            if (pin_low_q) begin
               state_d = ST_WAIT;
            end else if (tmr_q >= `RSS_START_CYC - 1) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            tmr_d = 32'h0;
            if (pin_low_q) begin
               state_d = ST_WAIT;
            end
         end
         default: begin
            state_d = ST_POR;
         end
      endcase
      // Any supply event restarts from the top
      if (supply_hold) begin
         state_d = ST_POR;
         tmr_d = 32'h0;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_POR;
         tmr_q <= 32'h0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
      end
   end

   // Cause events; set wins over a software clear
   // Losing a cause because software cleared in the same cycle would
   // hide a real reset, so the hardware event always takes priority
   // Core pulses arrive on mclk already and need no synchroniser
   always @* begin
      cause_set = 8'h00;
      cause_set[`RSS_CA_POR] = por_s;
      cause_set[`RSS_CA_DIP] = dip_trip_q | lpb_trip;
      cause_set[`RSS_CA_PIN] = pin_low_q;
      cause_set[`RSS_CA_WDT] = wdt_reset;
      cause_set[`RSS_CA_RI] = reset_instr;
      cause_set[`RSS_CA_OVF] = stack_overflow;
      cause_set[`RSS_CA_UNF] = stack_underflow;
      cause_set[`RSS_CA_PROG] = prog_exit;
   end

   // Software registers
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sw_en_q <= `RSS_BC_SW_EN_RST;
         fast_q <= `RSS_BC_FAST_RST;
         pullup_q <= `RSS_PC_PULLUP_RST;
         cause_q <= 8'h00;
      end else begin
         // Both bits are stored whatever the mode; only the mode decides use
         if (reg_wr && reg_addr == `RSS_ADDR_DIP_CTRL) begin
            sw_en_q <= reg_wdata[`RSS_BC_SW_EN]; // Stored in every mode
            fast_q <= reg_wdata[`RSS_BC_FAST];
         end
         if (reg_wr && reg_addr == `RSS_ADDR_PIN_CTRL) begin
            pullup_q <= reg_wdata[`RSS_PC_PULLUP];
         end
         if (reg_wr && reg_addr == `RSS_ADDR_CAUSE) begin
            cause_q <= (cause_q & ~reg_wdata) | cause_set;
         end else begin
            cause_q <= cause_q | cause_set;
         end
      end
   end

   // Read data one cycle after strobe, zero otherwise
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RSS_ADDR_DIP_CTRL: reg_rdata <= {sw_en_q, fast_q, 5'h00, dip_armed};
            `RSS_ADDR_CAUSE: reg_rdata <= cause_q;
            `RSS_ADDR_PIN_CTRL: reg_rdata <= {7'h00, pullup_q};
            `RSS_ADDR_STATUS: reg_rdata <= {5'h00, pin_low_q, state_q == ST_TIMER,
                                            state_q != ST_RUN};
            default: reg_rdata <= 8'h00; // Unmapped reads zero
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Registered outputs
   // Every output comes from a flop so downstream analog controls
   // never see combinational glitches from the mode decode
   // The hold is taken from the next state, saving one cycle of latency
   // The pin driver stays released in every state: the reset pin
   // is an input only, and an internal reset must not reach it
   // The pull-up stays on while the pin is a reset input, so an open
   // pin can never look like a reset request
   // In the waiting modes the detector is kept on through the whole
   // hold, so its ready report can gate the start of execution
   // Band-gap forcing only matters where the detector may turn off
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reset_hold <= 1'b1;
         external_reset_pin_out <= 1'b1;
         external_reset_pin_oe_n <= 1'b1;
         pin_pullup_en <= 1'b1;
         gpio_in <= 1'b1;
         brownout_det_en <= 1'b0;
         brownout_level <= 1'b0;
         bandgap_force <= 1'b0;
         low_power_brownout_en <= 1'b0;
      end else begin
         reset_hold <= (state_d != ST_RUN);
         // Pin is input only; internal resets never pull it
         external_reset_pin_out <= 1'b1;
         external_reset_pin_oe_n <= 1'b1;
         // Pull-up fixed on when pin is reset, else software
         pin_pullup_en <= pin_en | pullup_q;
         gpio_in <= pin_en ? 1'b1 : pin_s;
         brownout_det_en <= det_on | (start_wait && state_q != ST_RUN);
         brownout_level <= brownout_level_select;
         bandgap_force <= fast_q && (brownout_mode_select == `RSS_MODE_AWAKE ||
                                     brownout_mode_select == `RSS_MODE_SW);
         low_power_brownout_en <= low_power_brownout_enable;
      end
   end

endmodule

/* File: logic/rss_regs.vh */
`ifndef RSS_REGS_VH
`define RSS_REGS_VH
// Register addresses (byte address = index * 4 not used; plain 8-bit port)
`define RSS_ADDR_W 4
`define RSS_ADDR_DIP_CTRL 4'h0
`define RSS_ADDR_CAUSE 4'h1
`define RSS_ADDR_PIN_CTRL 4'h2
`define RSS_ADDR_STATUS 4'h3
// Brownout control fields
`define RSS_BC_SW_EN 7
`define RSS_BC_FAST 6
`define RSS_BC_READY 0
`define RSS_BC_SW_EN_RST 1'b1
`define RSS_BC_FAST_RST 1'b0
// Cause register fields (1 = seen; written 1 clears)
`define RSS_CA_POR 0
`define RSS_CA_DIP 1
`define RSS_CA_PIN 2
`define RSS_CA_WDT 3
`define RSS_CA_RI 4
`define RSS_CA_OVF 5
`define RSS_CA_UNF 6
`define RSS_CA_PROG 7
// Pin control fields
`define RSS_PC_PULLUP 0
`define RSS_PC_PULLUP_RST 1'b1
// Status fields
`define RSS_ST_HOLD 0
`define RSS_ST_TIMER 1
`define RSS_ST_PIN 2
// Brownout mode encodings
`define RSS_MODE_OFF 2'b00
`define RSS_MODE_SW 2'b01
`define RSS_MODE_AWAKE 2'b10
`define RSS_MODE_ON 2'b11
// Timing
`define RSS_CLK_MHZ 100
`define RSS_TIMER_MS 64
`define RSS_START_CYC 10
`define RSS_FILT_CYC 16
`endif

/* File: verification/rss_asserts.sv */
`timescale 1ns/1ps
module rss_asserts (
   input wire mclk,
   input wire rst_n,
   input wire ext_reset_pin_enable,
   input wire low_voltage_programming,
   input wire external_reset_pin_in,
   input wire external_reset_pin_out,
   input wire external_reset_pin_oe_n,
   input wire gpio_in,
   input wire brownout_level_select,
   input wire brownout_level,
   input wire low_power_brownout_enable,
   input wire low_power_brownout_en,
   input wire [1:0] brownout_mode_select,
   input wire bandgap_force,
   input wire por_active,
   input wire reset_hold,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr
);
   wire pin_en = ext_reset_pin_enable | low_voltage_programming; // Pin acts as reset
   wire m_fs = brownout_mode_select == 2'b10 || brownout_mode_select == 2'b01; // Fast start honoured
   reg fast_q; // Shadow of the fast start bit
   // Shadow copy, so band-gap forcing can be judged without a bus read
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         fast_q <= 1'b0;
      else if (reg_wr && reg_addr == 4'h0)
         fast_q <= reg_wdata[6];
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_pin_not_driven: assert property (external_reset_pin_oe_n && external_reset_pin_out)
      else $error("reset pin driven");
   chk_pin_low_holds: assert property ((pin_en && !external_reset_pin_in)[*8] |-> ##[0:3] reset_hold)
      else $error("long pin low did not hold");
   chk_gpio_follows: assert property ((!pin_en && $stable(external_reset_pin_in))[*4]
      |-> gpio_in == external_reset_pin_in)
      else $error("general input mismatch");
   chk_level_copy: assert property ($stable(brownout_level_select)[*2] |-> brownout_level == brownout_level_select)
      else $error("level select not applied");
   chk_lp_enable: assert property ($stable(low_power_brownout_enable)[*2]
      |-> low_power_brownout_en == low_power_brownout_enable)
      else $error("low-power enable mismatch");
   chk_bandgap_mode: assert property ($stable({brownout_mode_select, fast_q})[*3]
      |-> bandgap_force == (fast_q && m_fs))
      else $error("band-gap force mismatch");
   chk_por_holds: assert property (por_active[*5] |-> reset_hold)
      else $error("power-on not holding");
   chk_start_gap: assert property ($fell(reset_hold) && pin_en |-> $past(external_reset_pin_in, 10))
      else $error("start too soon after pin release");
endmodule
bind rss_reset_source_sequencer rss_asserts u_chk (.*);

/* File: verification/rss_far_side.sv */
`timescale 1ns/1ps
module rss_far_side #(
   parameter RDY_DLY = 3 // Detector warm-up cycles
) (
   input wire mclk,
   input wire por_c,
   input wire dip_c,
   input wire lp_c,
   input wire pin_c,
   input wire det_en,
   input wire p_out,
   input wire p_oe_n,
   input wire pu,
   output wire rdy,
   output wire por_a,
   output wire below,
   output wire lp_b,
   output wire pin
);
   reg [3:0] cnt_q = 4'h0; // Warm-up count
   reg rdy_q = 1'b0; // Ready report
   reg last_q = 1'b1; // Last pin level
   // Ready only after warm-up, lost at once on disable
   always @(posedge mclk) begin
      cnt_q <= !det_en ? 4'h0 : (cnt_q == RDY_DLY) ? cnt_q : cnt_q + 4'h1;
      rdy_q <= det_en && cnt_q == RDY_DLY;
      last_q <= pin;
   end
   assign rdy = rdy_q;
   assign por_a = por_c;
   assign below = dip_c & det_en; // Comparator silent while off
   assign lp_b = lp_c;
   // Device drive, outside pull-down, pull-up, else a floating pin that wanders
   assign pin = !p_oe_n ? p_out : pin_c ? 1'b0 : pu ? 1'b1 : ~last_q;
endmodule

/* File: verification/rss_reset_source_sequencer_tb.sv */
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_reset_source_sequencer_tb;
   localparam TMR_LEN = 50; // Shortened power-up count
   logic mclk = 1'b0, rst_n = 1'b0, pte_n = 1'b0, lvl = 1'b0, lp_en = 1'b0;
   logic ext_en = 1'b1, lv_prog = 1'b0, slp = 1'b0, wr = 1'b0, rd = 1'b0;
   logic por_c = 1'b1, dip_c = 1'b0, lp_c = 1'b0, pin_c = 1'b0; // Far-side commands
   logic [1:0] mode = 2'b11;
   logic [4:0] src = 5'h00; // Core reset pulses
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, d;
   wire por_a, below, rdy, lp_b, pin, p_out, p_oe_n, pu, gpio, det_en, lvl_o, bg, hold;
   wire [7:0] rdata;
   int err_total = 0, n_tests = 0, cyc_cnt = 0, n;
   rss_reset_source_sequencer #(.TIMER_CYCLES(TMR_LEN), .FILT_CYCLES(4), .PIN_FILT_CYCLES(4)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .powerup_timer_enable_n(pte_n), .brownout_mode_select(mode),
      .brownout_level_select(lvl), .low_power_brownout_enable(lp_en), .ext_reset_pin_enable(ext_en),
      .low_voltage_programming(lv_prog), .por_active(por_a), .brownout_below(below),
      .brownout_det_ready(rdy), .low_power_brownout_below(lp_b), .sleep_active(slp),
      .wdt_reset(src[0]), .reset_instr(src[1]), .stack_overflow(src[2]), .stack_underflow(src[3]),
      .prog_exit(src[4]), .external_reset_pin_in(pin), .external_reset_pin_out(p_out),
      .external_reset_pin_oe_n(p_oe_n), .pin_pullup_en(pu), .gpio_in(gpio), .brownout_det_en(det_en),
      .brownout_level(lvl_o), .bandgap_force(bg), .low_power_brownout_en(), .reset_hold(hold),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
   rss_far_side u_far (.mclk(mclk), .por_c(por_c), .dip_c(dip_c), .lp_c(lp_c), .pin_c(pin_c),
      .det_en(det_en), .p_out(p_out), .p_oe_n(p_oe_n), .pu(pu), .rdy(rdy), .por_a(por_a),
      .below(below), .lp_b(lp_b), .pin(pin));
   task cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      // Data stands only in the cycle after the strobe; take it mid-cycle
      @(negedge mclk);
      d = rdata;
   endtask
   // Bounded wait for the hold to reach a level
   task wait_hold(input logic v);
      n = 0;
      while (hold !== v && n < 300) begin
         @(posedge mclk);
         n++;
      end
      chk(hold, v);
   endtask
   task t_boot;
      cyc(TMR_LEN + 10);
      chk(hold, 1'b1);
      por_c <= 1'b0;
      wait_hold(1'b0);
      chk(8'(n >= TMR_LEN && n <= TMR_LEN + 40), 8'h01);
      rd_reg(`RSS_ADDR_DIP_CTRL);
      chk(d, 8'h81);
      rd_reg(`RSS_ADDR_STATUS);
      chk(d, 8'h00);
      rd_reg(4'hf);
      chk(d, 8'h00);
   endtask
   task t_ctrl;
      wr_reg(`RSS_ADDR_DIP_CTRL, 8'h7e);
      rd_reg(`RSS_ADDR_DIP_CTRL);
      chk(d, 8'h41);
      lvl <= 1'b1;
      cyc(4);
      chk({bg, det_en, lvl_o}, 3'b011);
      mode <= 2'b01;
      cyc(4);
      chk({bg, det_en}, 2'b10);
      rd_reg(`RSS_ADDR_DIP_CTRL);
      chk(d, 8'h40);
      wr_reg(`RSS_ADDR_DIP_CTRL, 8'h80);
      cyc(10);
      chk({bg, det_en, hold}, 3'b010);
      for (int i = 0; i < 8; i++) begin
         mode <= i[2:1];
         slp <= i[0];
         cyc(5);
         chk(det_en, i > 5 || (i > 1 && i < 5));
      end
      slp <= 1'b0;
   endtask
   task t_dip;
      wr_reg(`RSS_ADDR_CAUSE, 8'hff);
      dip_c <= 1'b1;
      cyc(3);
      dip_c <= 1'b0;
      cyc(15);
      chk(hold, 1'b0);
      dip_c <= 1'b1;
      cyc(12);
      chk(hold, 1'b1);
      dip_c <= 1'b0;
      wait_hold(1'b0);
      chk(8'(n >= TMR_LEN && n <= TMR_LEN + 40), 8'h01);
      rd_reg(`RSS_ADDR_CAUSE);
      chk(d[1], 1'b1);
   endtask
   task t_lp;
      wr_reg(`RSS_ADDR_CAUSE, 8'hff);
      lp_c <= 1'b1;
      cyc(15);
      chk(hold, 1'b0);
      lp_en <= 1'b1;
      cyc(15);
      chk(hold, 1'b1);
      lp_c <= 1'b0;
      lp_en <= 1'b0;
      wait_hold(1'b0);
      rd_reg(`RSS_ADDR_CAUSE);
      chk(d[1], 1'b1);
   endtask
   task t_pin;
      for (int i = 0; i < 4; i++) begin
         {ext_en, lv_prog} <= i[1:0];
         pin_c <= 1'b1;
         cyc(3);
         pin_c <= 1'b0;
         cyc(15);
         chk(hold, 1'b0);
         pin_c <= 1'b1;
         cyc(TMR_LEN + 20);
         chk({hold, gpio}, i ? 2'b11 : 2'b00);
         rd_reg(`RSS_ADDR_STATUS);
         chk(d, i ? 8'h05 : 8'h00);
         pin_c <= 1'b0;
         wait_hold(1'b0);
         chk(8'(i == 0 || (n >= 11 && n <= 30)), 8'h01);
      end
      {ext_en, lv_prog} <= 2'b00;
      wr_reg(`RSS_ADDR_PIN_CTRL, 8'h00);
      cyc(3);
      chk({pu, hold}, 2'b00);
      ext_en <= 1'b1;
      cyc(3);
      chk(pu, 1'b1);
      wr_reg(`RSS_ADDR_PIN_CTRL, 8'h01);
      wait_hold(1'b0);
   endtask
   task t_src;
      for (int i = 0; i < 5; i++) begin
         wr_reg(`RSS_ADDR_CAUSE, 8'hff);
         @(posedge mclk);
         src <= 5'h01 << i;
         @(posedge mclk);
         src <= 5'h00;
         rd_reg(`RSS_ADDR_CAUSE);
         chk(d, 8'h08 << i);
      end
   endtask
   task final_report;
      $display("checks=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      forever #5 mclk = ~mclk;
   end
   // Hang guard, well above the thousand or so cycles the run needs
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         final_report;
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_boot;
      t_ctrl;
      t_dip;
      t_lp;
      t_pin;
      t_src;
      final_report;
   end
endmodule
